//--- design/stlc_pkg.sv
package stlc_pkg;

	// ----------------------------------------------------------------
	// Register word indices on the internal register port.
	// ----------------------------------------------------------------
	localparam logic [9:0] SERIAL_PORT_SETUP_ADDR     = 10'h1a9;
	localparam logic [9:0] TRACE_BEGIN_POINT_ADDR     = 10'h1aa;
	localparam logic [9:0] TRACE_END_POINT_ADDR       = 10'h1ab;
	localparam logic [9:0] TRACE_SETUP_ADDR           = 10'h1ac;
	localparam logic [9:0] WRITE_PROTECT_CONTROL_ADDR = 10'h1ad;
	localparam logic [9:0] UNLOCK_KEY_ADDR            = 10'h1af;

	// ----------------------------------------------------------------
	// Field positions and reset values.
	// ----------------------------------------------------------------
	localparam int          SLEW_BIT         = 7;
	localparam int          BURST_FMT_BIT    = 6;
	localparam int          BAD_FRAME_IRQ_BIT = 5;
	localparam int          GAP_LSB          = 0;
	localparam int          GAP_W            = 5;
	localparam logic [4:0]  GAP_RESET        = 5'h0a;
	localparam logic [7:0]  SERIAL_SETUP_RESET = 8'h0a;
	localparam int          ADDR_W           = 10;
	localparam int          TRACE_RUN_BIT    = 15;
	localparam int          CORE_SEL_LSB     = 8;
	localparam int          TAIL_LSB         = 0;
	localparam logic [7:0]  TAIL_ENDLESS     = 8'hff;
	localparam logic [15:0] UNLOCK_KEY       = 16'h1337;
	localparam int          NUM_RAMS         = 3;
	localparam int          RAM_ADDR_W       = 10;
	localparam logic [9:0]  TAIL_GUARD_SPAN  = 10'h010;

	// ----------------------------------------------------------------
	// Gap watchdog unit length in system clocks.
	// ----------------------------------------------------------------
	localparam logic [20:0] GAP_UNIT_CYCLES  = 21'h008000;

	// Trace unit phases.
	typedef enum logic [1:0] {
		TR_IDLE = 2'b00,
		TR_SYNC = 2'b01,
		TR_RUN  = 2'b10,
		TR_TAIL = 2'b11
	} stlc_phase_type;

endpackage

//--- design/stlc_gap_watch.sv
`timescale 1ns/100ps
// Counts chip-select idle time inside a format A burst and flags overrun.
module stlc_gap_watch (
	input  wire logic                         mclk,
	input  wire logic                         rst_n,
	input  wire logic                         enable,
	input  wire logic                         cs_idle_in_burst,
	input  wire logic [stlc_pkg::GAP_W-1:0]   gap_limit,
	output logic                              gap_expired
);
	import stlc_pkg::*;

	// ----------------------------------------------------------------
	// Idle counter.
	// ----------------------------------------------------------------
	logic [25:0] idle_cnt_ff;   // Cycles spent idle so far.
	logic [25:0] limit_cycles;  // (limit + 1) * 32768.

	assign limit_cycles = {(6'(gap_limit) + 6'h01), 20'h00000} >> 5;

	// Counter restarts whenever the select comes back or watching stops.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			idle_cnt_ff <= 26'h0000000;
			gap_expired <= 1'b0;
		end else if (!enable || !cs_idle_in_burst) begin
			idle_cnt_ff <= 26'h0000000;
			gap_expired <= 1'b0;
		end else if (idle_cnt_ff >= limit_cycles - 26'h0000001) begin
			// Pulse once per overrun, then hold the count.
			gap_expired <= (idle_cnt_ff == limit_cycles - 26'h0000001);
			idle_cnt_ff <= limit_cycles;
		end else begin
			idle_cnt_ff <= idle_cnt_ff + 26'h0000001;
			gap_expired <= 1'b0;
		end
	end

endmodule

//--- design/stlc_config_regs.sv
`timescale 1ns/100ps
// How it works
// - slew bit picks slow or fast output edges.
// - format bit picks burst format A or B.
// - bad frame raises interrupt when enabled.
// - format A gap limited to (limit+1)*32768 clocks.
// - format may change any time while unlocked, no reset.
// - idle trace sends sync at start address.
// - trace phase ends at stop address.
// - run bit starts trace; clearing halts immediately.
// - run bit clears itself after all phases.
// - three-bit select picks traced core.
// - tail phase lasts tail-length clocks.
// - tail 255 traces endlessly until run cleared.
// - locked registers readable, writes ignored.
// - lock set by write, cleared only by key.
// - global lock blocks writes to lockable bits.
// - each guard protects last 16 RAM addresses.
// - each guard locks itself, independent of global.
// - correct key clears all three guards too.
// - key value 1337h clears the lock.
module stlc_config_regs (
	input  wire logic                          mclk,
	input  wire logic                          rst_n,
	// Register port.
	input  wire logic                          reg_wr,
	input  wire logic                          reg_rd,
	input  wire logic [stlc_pkg::ADDR_W-1:0]   reg_addr,
	input  wire logic [15:0]                   reg_wdata,
	output logic      [15:0]                   reg_rdata,
	// Serial port controls.
	output logic                               slew_fast,
	output logic                               burst_fmt_b,
	input  wire logic                          bad_frame,
	output logic                               bad_frame_irq,
	input  wire logic                          cs_idle_in_burst,
	output logic                               gap_timeout,
	// Program counters of the six cores.
	input  wire logic [15:0]                   core_program_counter_0,
	input  wire logic [15:0]                   core_program_counter_1,
	input  wire logic [15:0]                   core_program_counter_2,
	input  wire logic [15:0]                   core_program_counter_3,
	input  wire logic [15:0]                   core_program_counter_4,
	input  wire logic [15:0]                   core_program_counter_5,
	// Trace unit status.
	output logic                               trace_sync_pulse,
	output logic                               trace_active,
	output logic [1:0]                         trace_phase,
	output logic [2:0]                         target_core_sel,
	// Write protection.
	output logic                               device_locked,
	input  wire logic [stlc_pkg::NUM_RAMS-1:0]  ram_wr,
	input  wire logic [stlc_pkg::RAM_ADDR_W-1:0] ram_wr_addr,
	input  wire logic [stlc_pkg::RAM_ADDR_W-1:0] ram_top_addr,
	output logic      [stlc_pkg::NUM_RAMS-1:0]   ram_wr_allow,
	output logic                               ram1_tail_guard,
	output logic                               ram2_tail_guard,
	output logic                               ram3_tail_guard
);
	import stlc_pkg::*;

	// ----------------------------------------------------------------
	// Storage.
	// ----------------------------------------------------------------
	// Register fields.
	logic [7:0]           serial_setup_ff;  // Slew, format, irq enable, gap limit.
	logic [9:0]           begin_point_ff;   // Trace start address.
	logic [9:0]           end_point_ff;     // Trace stop address.
	logic                 run_ff;           // Trace run bit.
	logic [2:0]           core_sel_ff;      // Traced core code.
	logic [7:0]           tail_len_ff;      // Tail phase length.
	logic                 lock_ff;          // Global write lock.
	logic [NUM_RAMS-1:0]  guard_ff;         // Per-RAM tail guards.

	// Sequencer state.
	stlc_phase_type       phase_ff;         // Trace phase.
	logic [7:0]           tail_cnt_ff;      // Tail cycles elapsed.

	// Flags and derived signals.
	logic                 irq_ff;           // Bad-frame interrupt request.
	logic [15:0]          rdata_ff;         // Read data register.
	logic [15:0]          sel_pc;           // Program counter of traced core.
	logic                 key_ok;           // Correct unlock key written.
	logic                 gap_pulse;        // Watchdog overrun.
	logic                 tail_done;        // Tail count has run out.
	logic                 halt_wr;          // Write that clears the run bit.

	// Register write decode, used for every register.
	function automatic logic wr_hit(input logic [ADDR_W-1:0] a);
		wr_hit = reg_wr && (reg_addr == a);
	endfunction

	// Kept in a process so that it wakes on the strobe
	// and address that the decode function reads.
	always_comb begin
		key_ok    = wr_hit(UNLOCK_KEY_ADDR) && (reg_wdata == UNLOCK_KEY);
		// A run bit written low sends the sequencer to idle.
		halt_wr   = wr_hit(TRACE_SETUP_ADDR) && !reg_wdata[TRACE_RUN_BIT];
		// A tail length of zero ends after one cycle.
		tail_done = (phase_ff == TR_TAIL) && (tail_len_ff != TAIL_ENDLESS) &&
		            ((tail_cnt_ff >= tail_len_ff - 8'h01) || (tail_len_ff == 8'h00));
	end

	// ----------------------------------------------------------------
	// Serial port setup; every bit here is lockable.
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			// Gap limit ten, other bits clear.
			serial_setup_ff <= SERIAL_SETUP_RESET;
		end else if (wr_hit(SERIAL_PORT_SETUP_ADDR) && !lock_ff) begin
			// Format may be rewritten at any time while unlocked; it takes effect at once.
			serial_setup_ff <= reg_wdata[7:0];
		end
	end

	// Both act on the edge after the write.
	assign slew_fast   = serial_setup_ff[SLEW_BIT];
	assign burst_fmt_b = serial_setup_ff[BURST_FMT_BIT];

	// ----------------------------------------------------------------
	// Bad-frame interrupt; an event beats a clearing read.
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			// No request after reset.
			irq_ff <= 1'b0;
		end else if ((bad_frame || gap_pulse) && serial_setup_ff[BAD_FRAME_IRQ_BIT]) begin
			// A new event wins over a read.
			irq_ff <= 1'b1;
		end else if (!serial_setup_ff[BAD_FRAME_IRQ_BIT]) begin
			// Disabling drops a pending request.
			irq_ff <= 1'b0;
		end else if (reg_rd && reg_addr == SERIAL_PORT_SETUP_ADDR) begin
			// Reading the setup register acknowledges the request.
			irq_ff <= 1'b0;
		end
	end

	assign bad_frame_irq = irq_ff;

	// ----------------------------------------------------------------
	// Gap watchdog, only meaningful in format A.
	// ----------------------------------------------------------------
	// Format B has no gap limit.
	stlc_gap_watch u_gap (
		.mclk             (mclk),
		.rst_n            (rst_n),
		.enable           (!burst_fmt_b),
		.cs_idle_in_burst (cs_idle_in_burst),
		.gap_limit        (serial_setup_ff[GAP_LSB +: GAP_W]),
		.gap_expired      (gap_pulse)
	);

	// The overrun also raises the request.
	assign gap_timeout = gap_pulse;

	// ----------------------------------------------------------------
	// Trace addresses; not lockable.
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			// Both points start at zero.
			begin_point_ff <= 10'h000;
			end_point_ff   <= 10'h000;
		end else begin
			// Never locked, so tracing stays usable.
			if (wr_hit(TRACE_BEGIN_POINT_ADDR)) begin
				begin_point_ff <= reg_wdata[9:0];
			end
			if (wr_hit(TRACE_END_POINT_ADDR)) begin
				end_point_ff <= reg_wdata[9:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// Traced core selection.
	// ----------------------------------------------------------------
	// Only the low ten counter bits are compared.
	// Codes six and seven trace nothing useful.
	always_comb begin
		unique case (core_sel_ff)
			3'h0:    sel_pc = core_program_counter_0;
			3'h1:    sel_pc = core_program_counter_1;
			3'h2:    sel_pc = core_program_counter_2;
			3'h3:    sel_pc = core_program_counter_3;
			3'h4:    sel_pc = core_program_counter_4;
			3'h5:    sel_pc = core_program_counter_5;
			default: sel_pc = 16'h0000;  // Unused codes trace nothing real.
		endcase
	end

	// ----------------------------------------------------------------
	// Trace setup fields; run bit also cleared by the sequencer.
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			// Stopped, core zero, no tail.
			run_ff      <= 1'b0;
			core_sel_ff <= 3'h0;
			tail_len_ff <= 8'h00;
		end else if (wr_hit(TRACE_SETUP_ADDR)) begin
			run_ff      <= reg_wdata[TRACE_RUN_BIT];
			core_sel_ff <= reg_wdata[CORE_SEL_LSB +: 3];
			tail_len_ff <= reg_wdata[TAIL_LSB +: 8];
		end else if (tail_done) begin
			// Run bit drops with the phase.
			run_ff <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Trace sequencer.
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			// Idle, tail count cleared.
			phase_ff    <= TR_IDLE;
			tail_cnt_ff <= 8'h00;
		end else if (!run_ff || halt_wr) begin
			// A run bit written low stops output on that same edge.
			phase_ff    <= TR_IDLE;
			tail_cnt_ff <= 8'h00;
		end else begin
			unique case (phase_ff)
				TR_IDLE: begin
					// Wait for the start point.
					if (sel_pc[9:0] == begin_point_ff) begin
						phase_ff <= TR_SYNC;
					end
				end
				TR_SYNC: begin
					// One cycle marks the sync code launch.
					phase_ff <= TR_RUN;
				end
				TR_RUN: begin
					// Trace until the stop point.
					if (sel_pc[9:0] == end_point_ff) begin
						phase_ff    <= TR_TAIL;
						tail_cnt_ff <= 8'h00;
					end
				end
				TR_TAIL: begin
					// An endless tail holds until software stops it.
					if (tail_len_ff == TAIL_ENDLESS) begin
						phase_ff <= TR_TAIL;
					end else if (tail_done) begin
						phase_ff <= TR_IDLE;
					end else begin
						// One more tail cycle.
						tail_cnt_ff <= tail_cnt_ff + 8'h01;
					end
				end
			endcase
		end
	end

	// Status follows the phase register, active also gated by the run bit; core select comes from its field.
	assign trace_sync_pulse = (phase_ff == TR_SYNC);
	assign trace_active     = (phase_ff != TR_IDLE) && run_ff;
	assign trace_phase      = phase_ff;
	assign target_core_sel  = core_sel_ff;

	// ----------------------------------------------------------------
	// Global lock: settable by write, cleared only by the key.
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			// Unlocked after reset.
			lock_ff <= 1'b0;
		end else if (key_ok) begin
			// The key beats a lock write.
			lock_ff <= 1'b0;
		end else if (wr_hit(WRITE_PROTECT_CONTROL_ADDR) && reg_wdata[0]) begin
			// A zero in bit 0 leaves the lock alone.
			lock_ff <= 1'b1;
		end
	end

	assign device_locked = lock_ff;

	// ----------------------------------------------------------------
	// RAM tail guards, each locked by itself once set.
	// ----------------------------------------------------------------
	// One guard flop per RAM.
	genvar gi;
	generate
		for (gi = 0; gi < NUM_RAMS; gi++) begin : g_guard
			always_ff @(posedge mclk or negedge rst_n) begin
				if (!rst_n) begin
					// All guards open after reset.
					guard_ff[gi] <= 1'b0;
				end else if (key_ok) begin
					guard_ff[gi] <= 1'b0;
				end else if (wr_hit(WRITE_PROTECT_CONTROL_ADDR) && !guard_ff[gi] &&
				             reg_wdata[gi+1]) begin
					// A set guard ignores writes.
					guard_ff[gi] <= 1'b1;
				end
			end

			// Writes into the top sixteen words are refused while guarded.
			assign ram_wr_allow[gi] = ram_wr[gi] && !(guard_ff[gi] &&
				(ram_wr_addr > ram_top_addr - TAIL_GUARD_SPAN) &&
				(ram_wr_addr <= ram_top_addr));
		end
	endgenerate

	// Guard bits sit above the lock bit.
	assign ram1_tail_guard = guard_ff[0];
	assign ram2_tail_guard = guard_ff[1];
	assign ram3_tail_guard = guard_ff[2];

	// ----------------------------------------------------------------
	// Read path, one cycle after the strobe; reads ignore locks.
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			// Zero until the first read.
			rdata_ff <= 16'h0000;
		end else if (reg_rd) begin
			// Locks never hide a register.
			unique case (reg_addr)
				SERIAL_PORT_SETUP_ADDR:     rdata_ff <= {8'h00, serial_setup_ff};
				TRACE_BEGIN_POINT_ADDR:     rdata_ff <= {6'h00, begin_point_ff};
				TRACE_END_POINT_ADDR:       rdata_ff <= {6'h00, end_point_ff};
				TRACE_SETUP_ADDR:           rdata_ff <= {run_ff, 4'h0, core_sel_ff,
				                                         tail_len_ff};
				WRITE_PROTECT_CONTROL_ADDR: rdata_ff <= {12'h000, guard_ff, lock_ff};
				// Unmapped words read as zero.
				default:                    rdata_ff <= 16'h0000;
			endcase
		end
	end

	// Data holds until the next read.
	assign reg_rdata = rdata_ff;

endmodule

//--- verification/stlc_config_sva.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Port checker for the configuration bank.
// ----------------------------------------------------------------
module stlc_config_sva (
	input wire logic                              mclk,
	input wire logic                              rst_n,
	input wire logic                              reg_wr,
	input wire logic [stlc_pkg::ADDR_W-1:0]       reg_addr,
	input wire logic [15:0]                       reg_wdata,
	input wire logic                              slew_fast,
	input wire logic                              burst_fmt_b,
	input wire logic                              gap_timeout,
	input wire logic                              trace_sync_pulse,
	input wire logic                              trace_active,
	input wire logic [1:0]                        trace_phase,
	input wire logic [2:0]                        target_core_sel,
	input wire logic                              device_locked,
	input wire logic [stlc_pkg::NUM_RAMS-1:0]     ram_wr,
	input wire logic [stlc_pkg::RAM_ADDR_W-1:0]   ram_wr_addr,
	input wire logic [stlc_pkg::RAM_ADDR_W-1:0]   ram_top_addr,
	input wire logic [stlc_pkg::NUM_RAMS-1:0]     ram_wr_allow,
	input wire logic                              ram1_tail_guard,
	input wire logic                              ram2_tail_guard,
	input wire logic                              ram3_tail_guard
);
	import stlc_pkg::*;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	// Decoded accesses.
	wire logic       wr_cfg  = reg_wr && reg_addr == SERIAL_PORT_SETUP_ADDR;
	wire logic       wr_trc  = reg_wr && reg_addr == TRACE_SETUP_ADDR;
	wire logic       wr_key  = reg_wr && reg_addr == UNLOCK_KEY_ADDR && reg_wdata == UNLOCK_KEY;
	wire logic [2:0] guards  = {ram3_tail_guard, ram2_tail_guard, ram1_tail_guard};
	// Top 16 words of a RAM; assumes the RAM is at least 16 words deep.
	wire logic       in_tail = ram_wr_addr >= ram_top_addr - 10'h00f && ram_wr_addr <= ram_top_addr;

	slew_follow_a: assert property (wr_cfg && !device_locked |=> slew_fast == $past(reg_wdata[SLEW_BIT]))
		else $error("slew select did not follow the write");
	burst_follow_a: assert property (wr_cfg && !device_locked |=> burst_fmt_b == $past(reg_wdata[6]))
		else $error("burst format did not follow the write");
	locked_cfg_a: assert property (wr_cfg && device_locked |=> $stable({slew_fast, burst_fmt_b}))
		else $error("locked setup changed");
	lock_hold_a: assert property (device_locked && !wr_key |=> device_locked)
		else $error("lock dropped without key");
	unlock_clear_a: assert property (wr_key |=> !device_locked && guards == 3'b000)
		else $error("key did not clear locks");
	guard_sticky_a: assert property (!wr_key |=> (guards & $past(guards)) == $past(guards))
		else $error("tail guard cleared without key");
	guard_gate_a: assert property (ram_wr_allow == (ram_wr & ~(guards & {3{in_tail}})))
		else $error("ram write gating wrong");
	sync_step_a: assert property (trace_sync_pulse |-> trace_phase == TR_SYNC
		##1 (trace_phase == TR_RUN || trace_phase == TR_IDLE)) else $error("sync not followed by run");
	idle_order_a: assert property (trace_phase == TR_IDLE |=> trace_phase[1] == 1'b0)
		else $error("idle skipped sync");
	halt_now_a: assert property (wr_trc && !reg_wdata[TRACE_RUN_BIT] |=> trace_phase == TR_IDLE
		&& !trace_active) else $error("trace not halted");
	core_sel_a: assert property (wr_trc |=> target_core_sel == $past(reg_wdata[10:8]))
		else $error("core select not taken");
	tail_seen_c: cover property (trace_phase == TR_TAIL);
	unlock_seen_c: cover property (wr_key && device_locked);
	gap_seen_c: cover property (gap_timeout);
endmodule

bind stlc_config_regs stlc_config_sva stlc_config_sva_inst (
	.mclk(mclk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.slew_fast(slew_fast), .burst_fmt_b(burst_fmt_b), .gap_timeout(gap_timeout),
	.trace_sync_pulse(trace_sync_pulse), .trace_active(trace_active), .trace_phase(trace_phase),
	.target_core_sel(target_core_sel), .device_locked(device_locked), .ram_wr(ram_wr),
	.ram_wr_addr(ram_wr_addr), .ram_top_addr(ram_top_addr), .ram_wr_allow(ram_wr_allow),
	.ram1_tail_guard(ram1_tail_guard), .ram2_tail_guard(ram2_tail_guard),
	.ram3_tail_guard(ram3_tail_guard));

//--- verification/stlc_mcu_model.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Microcontroller side: issues single-word register accesses.
// ----------------------------------------------------------------
module stlc_mcu_model (
	input  wire logic                        mclk,
	output logic                             reg_wr,
	output logic                             reg_rd,
	output logic [stlc_pkg::ADDR_W-1:0]      reg_addr,
	output logic [15:0]                      reg_wdata
);
	import stlc_pkg::*;
	// Bus is quiet at time zero.
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = '0;
		reg_wdata = 16'h0000;
	end
	// One word per access, strobe held over one edge; then junk on address and data.
	task automatic access(input logic wr, input logic [9:0] addr, input logic [15:0] data);
		@(negedge mclk);
		reg_wr = wr;
		reg_rd = !wr;
		reg_addr = addr;
		reg_wdata = data;
		@(negedge mclk);
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = ~reg_addr;
		reg_wdata = ~reg_wdata;
	endtask
endmodule

//--- verification/testbench.sv
`timescale 1ns/100ps
module testbench;
	import stlc_pkg::*;
	logic        mclk, rst_n, bad_frame, cs_idle_in_burst, reg_wr, reg_rd, rd_seen;
	logic        slew_fast, burst_fmt_b, bad_frame_irq, gap_timeout, trace_sync_pulse;
	logic        trace_active, device_locked, g1, g2, g3;
	logic [1:0]  trace_phase;
	logic [2:0]  target_core_sel, ram_wr, ram_wr_allow;
	logic [9:0]  reg_addr, ram_wr_addr, ram_top_addr, b;
	logic [15:0] reg_wdata, reg_rdata;
	logic [15:0] pc [6];
	logic [15:0] exp_q [$];
	logic [31:0] lfsr;
	int          err_total, total_checks, cyc, n;

	stlc_mcu_model stlc_mcu_model_inst (.mclk(mclk), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata));
	stlc_config_regs stlc_config_regs_inst (.mclk(mclk), .rst_n(rst_n), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.slew_fast(slew_fast), .burst_fmt_b(burst_fmt_b), .bad_frame(bad_frame),
		.bad_frame_irq(bad_frame_irq), .cs_idle_in_burst(cs_idle_in_burst),
		.gap_timeout(gap_timeout), .core_program_counter_0(pc[0]), .core_program_counter_1(pc[1]),
		.core_program_counter_2(pc[2]), .core_program_counter_3(pc[3]),
		.core_program_counter_4(pc[4]), .core_program_counter_5(pc[5]),
		.trace_sync_pulse(trace_sync_pulse), .trace_active(trace_active),
		.trace_phase(trace_phase), .target_core_sel(target_core_sel),
		.device_locked(device_locked), .ram_wr(ram_wr), .ram_wr_addr(ram_wr_addr),
		.ram_top_addr(ram_top_addr), .ram_wr_allow(ram_wr_allow), .ram1_tail_guard(g1),
		.ram2_tail_guard(g2), .ram3_tail_guard(g3));

	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic final_report();
		$display("checks %0d, mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic wr(input logic [9:0] a, input logic [15:0] d);
		stlc_mcu_model_inst.access(1'b1, a, d);
	endtask
	// The expected word is queued first; the watcher pairs it with the returned data.
	task automatic rd(input logic [9:0] a, input logic [15:0] e);
		exp_q.push_back(e);
		stlc_mcu_model_inst.access(1'b0, a, 16'h0000);
	endtask
	// Arms a trace on core c, then walks the core through the start and stop points.
	task automatic to_tail(input int c, input logic [7:0] t);
		lfsr = lfsr_next(lfsr);
		b = lfsr[9:0];
		for (int i = 0; i < 6; i++) pc[i] = {6'h0, b};
		pc[c] = {6'h0, ~b};
		wr(TRACE_BEGIN_POINT_ADDR, {6'h0, b});
		wr(TRACE_END_POINT_ADDR, {6'h0, b ^ 10'h155});
		wr(TRACE_SETUP_ADDR, {1'b1, 4'h0, 3'(c), t});
		repeat (3) @(negedge mclk);
		chk({11'h0, target_core_sel, trace_phase}, {11'h0, 3'(c), TR_IDLE});
		pc[c] = {6'h0, b};
		@(negedge mclk);
		chk({13'h0, trace_sync_pulse, trace_phase}, {13'h1, TR_SYNC});
		pc[c] = {6'h0, b ^ 10'h155};
		@(negedge mclk);
		chk({14'h0, trace_phase}, {14'h0, TR_RUN});
		@(negedge mclk);
		chk({13'h0, trace_active, trace_phase}, {13'h1, TR_TAIL});
	endtask

	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end
	// Read watcher and hang guard; one run needs roughly 33300 cycles.
	always @(posedge mclk) begin
		rd_seen <= reg_rd;
		cyc <= cyc + 1;
		if (cyc == 100000) begin
			err_total++;
			final_report();
		end
	end
	always @(negedge mclk) begin
		if (rd_seen === 1'b1 && exp_q.size() > 0)
			chk(reg_rdata, exp_q.pop_front());
	end

	initial begin
		{rst_n, bad_frame, cs_idle_in_burst, ram_wr, ram_wr_addr} = '0;
		ram_top_addr = 10'h3ff;
		lfsr = 32'h7483;
		for (int i = 0; i < 6; i++) pc[i] = 16'h0000;
		repeat (16) @(negedge mclk);
		rst_n = 1'b1;
		rd(SERIAL_PORT_SETUP_ADDR, 16'h000a);
		rd(WRITE_PROTECT_CONTROL_ADDR, 16'h0000);
		rd(10'h1b5, 16'h0000);
		for (int k = 0; k < 5; k++) begin
			wr(SERIAL_PORT_SETUP_ADDR, {8'h00, k[1], k[0], 6'h00});
			chk({14'h0, slew_fast, burst_fmt_b}, {14'h0, k[1:0]});
		end
		for (int k = 0; k < 2; k++) begin
			wr(SERIAL_PORT_SETUP_ADDR, {10'h0, k[0], 5'h00});
			bad_frame = 1'b1;
			@(negedge mclk);
			bad_frame = 1'b0;
			@(negedge mclk);
			chk({15'h0, bad_frame_irq}, {15'h0, k[0]});
		end
		rd(SERIAL_PORT_SETUP_ADDR, 16'h0020);
		chk({15'h0, bad_frame_irq}, 16'h0000);
		cs_idle_in_burst = 1'b1;
		n = 0;
		while (gap_timeout !== 1'b1 && n < 40000) begin
			@(negedge mclk);
			n++;
		end
		cs_idle_in_burst = 1'b0;
		chk({15'h0, n >= 32768 && n <= 32769}, 16'h0001);
		for (int c = 0; c < 6; c++) begin
			to_tail(c, 8'(c + 2));
			n = 0;
			while (trace_phase === TR_TAIL && n < 300) begin
				@(negedge mclk);
				n++;
			end
			chk(16'(n), 16'(c + 2));
			rd(TRACE_SETUP_ADDR, {5'h0, 3'(c), 8'(c + 2)});
		end
		to_tail(0, 8'h00);
		repeat (2) @(negedge mclk);
		chk({14'h0, trace_phase}, {14'h0, TR_IDLE});
		rd(TRACE_SETUP_ADDR, 16'h0000);
		to_tail(5, TAIL_ENDLESS);
		repeat (300) @(negedge mclk);
		chk({14'h0, trace_phase}, {14'h0, TR_TAIL});
		wr(TRACE_SETUP_ADDR, 16'h0000);
		chk({13'h0, trace_active, trace_phase}, 16'h0000);
		wr(SERIAL_PORT_SETUP_ADDR, 16'h0040);
		wr(WRITE_PROTECT_CONTROL_ADDR, 16'h0005);
		wr(SERIAL_PORT_SETUP_ADDR, 16'h00bf);
		wr(WRITE_PROTECT_CONTROL_ADDR, 16'h000a);
		chk({12'h0, g3, g2, g1, device_locked}, 16'h000f);
		wr(TRACE_BEGIN_POINT_ADDR, 16'h0123);
		rd(SERIAL_PORT_SETUP_ADDR, 16'h0040);
		rd(WRITE_PROTECT_CONTROL_ADDR, 16'h000f);
		rd(TRACE_BEGIN_POINT_ADDR, 16'h0123);
		ram_wr = 3'b111;
		for (int a = 0; a < 4; a++) begin
			ram_wr_addr = 10'h3ee + a[9:0];
			@(negedge mclk);
			chk({13'h0, ram_wr_allow}, (a < 2) ? 16'h0007 : 16'h0000);
		end
		wr(UNLOCK_KEY_ADDR, 16'h1336);
		rd(WRITE_PROTECT_CONTROL_ADDR, 16'h000f);
		wr(UNLOCK_KEY_ADDR, UNLOCK_KEY);
		chk({12'h0, g3, g2, g1, device_locked}, 16'h0000);
		rd(WRITE_PROTECT_CONTROL_ADDR, 16'h0000);
		wr(WRITE_PROTECT_CONTROL_ADDR, 16'h0002);
		wr(SERIAL_PORT_SETUP_ADDR, 16'h0080);
		rd(SERIAL_PORT_SETUP_ADDR, 16'h0080);
		chk({13'h0, ram_wr_allow}, 16'h0006);
		repeat (2) @(negedge mclk);
		final_report();
	end
endmodule
